// [rtl/pfcps_pkg.sv]
// Package of constants and carrier types for the protection fault sequencer
package pfcps_pkg;

    // ----------------------------------------
    // Clock and timing
    // ----------------------------------------
    localparam int CLK_MHZ = 50;
    localparam int PCL_TIME_NS = 200;
    localparam int BROWNOUT_TIME_US = 20;
    localparam int OPEN_LOOP_TIME_US = 1;
    localparam int FOLLOW_CANCEL_TIME_US = 1;
    localparam int OV_TIME_US = 12;
    localparam int MODE_SAMPLE_TIME_US = 18;
    localparam int STANDBY_TIME_US = 9;
    // Least times round up to whole cycles
    localparam int PCL_CYC = (PCL_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int BROWNOUT_CYC = BROWNOUT_TIME_US * CLK_MHZ;
    localparam int OPEN_LOOP_CYC = OPEN_LOOP_TIME_US * CLK_MHZ;
    localparam int FOLLOW_CANCEL_CYC = FOLLOW_CANCEL_TIME_US * CLK_MHZ;
    localparam int OV_CYC = OV_TIME_US * CLK_MHZ;
    localparam int MODE_SAMPLE_CYC = MODE_SAMPLE_TIME_US * CLK_MHZ;
    localparam int STANDBY_CYC = STANDBY_TIME_US * CLK_MHZ;
    // Counter width covers the longest qualifier
    localparam int CNT_W = 10;
    localparam logic [CNT_W-1:0] CNT_RESET = 10'h000;

    // ----------------------------------------
    // Qualifier channel indices
    // ----------------------------------------
    localparam int NQ = 7;
    localparam int Q_PCL = 0;
    localparam int Q_BROWN = 1;
    localparam int Q_OPEN = 2;
    localparam int Q_FCAN = 3;
    localparam int Q_OV1 = 4;
    localparam int Q_OV2 = 5;
    localparam int Q_STBY = 6;

    // ----------------------------------------
    // Sequencer states, one-hot
    // ----------------------------------------
    typedef enum logic [5:0] {
        PFCPS_OFF = 6'b00_0001,
        PFCPS_MODE = 6'b00_0010,
        PFCPS_RUN = 6'b00_0100,
        PFCPS_WAIT = 6'b00_1000,
        PFCPS_LATCH = 6'b01_0000,
        PFCPS_STBY = 6'b10_0000
    } pfcps_state_t;

    // Digitised comparator decisions, all raw from pins
    typedef struct packed {
        logic shunt_over;     // Amplified shunt sense past limit
        logic brown_low;      // Brownout input below 1V
        logic brown_high;     // Brownout input above 1.25V
        logic brown_lowline;  // Brownout input below 2.3V
        logic fb_low;         // Feedback sense below 0.5V
        logic fb_follow_low;  // Feedback sense below 0.8V
        logic fb_over;        // Feedback sense above 2.7V
        logic fb_under_rated; // Feedback sense below 2.5V
        logic ov2_over;       // Second over-voltage input above 2.5V
        logic ov2_under;      // Second over-voltage input below 2.3V
        logic thr_low;        // Threshold/enable pin below 0.5V
        logic load_light;     // Follower load input below 0.5V
        logic bulk_95;        // Bulk above 95 percent of rated
        logic bulk_low_thr;   // Bulk below programmed lower level
    } pfcps_cmp_t;

    localparam int NCMP = 14;

endpackage

// [rtl/pfcps_sequencer.sv]
// Protection fault sequencer for a boost PFC controller
`timescale 1ns/10ps

module pfcps_sequencer (
    // Clock, reset, enable
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    // Comparator decisions from the analog side
    input wire pfcps_pkg::pfcps_cmp_t cmp_in,
    input wire logic supply_undervoltage_lockout,
    input wire logic vref_up,
    // PWM timing and soft-start status from regulation logic
    input wire logic min_off_pulse,
    input wire logic pwm_on_req,
    input wire logic soft_start_active,
    // Outputs
    output logic gate_drive,
    output logic soft_start_req,
    output logic bulk_good_out,
    output logic follower_current_en,
    output logic latch_mode,
    output logic standby,
    output logic peak_current_limit,
    output logic open_loop_fault,
    output logic first_overvoltage_fault,
    output logic second_overvoltage_fault
);

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    localparam int NS = pfcps_pkg::NCMP + 1;

    logic [NS-1:0] raw_in; // Pin-side inputs
    logic [NS-1:0] meta_q; // First stage, read only by second
    logic [NS-1:0] sync_q; // Second stage, safe to use
    pfcps_pkg::pfcps_cmp_t c; // Synchronised comparator view
    logic supply_undervoltage_lockout_s; // Synchronised undervoltage

    assign raw_in = {supply_undervoltage_lockout, cmp_in};
    assign c = pfcps_pkg::pfcps_cmp_t'(sync_q[pfcps_pkg::NCMP-1:0]);
    assign supply_undervoltage_lockout_s = sync_q[pfcps_pkg::NCMP];

    // Two flops per pin; undervoltage resets to asserted
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            meta_q <= {1'b1, {pfcps_pkg::NCMP{1'b0}}};
            sync_q <= {1'b1, {pfcps_pkg::NCMP{1'b0}}};
        end else if (clk_en) begin
            meta_q <= raw_in;
            sync_q <= meta_q;
        end
    end

    // ----------------------------------------
    // Duration qualifiers
    // ----------------------------------------
    logic [pfcps_pkg::NQ-1:0] q_raw; // Condition present
    logic [pfcps_pkg::NQ-1:0] q_hit; // Held long enough
    logic follow_active; // Reduction current engaged
    pfcps_pkg::pfcps_state_t state_q;
    pfcps_pkg::pfcps_state_t state_d;

    assign q_raw[pfcps_pkg::Q_PCL] = c.shunt_over;
    assign q_raw[pfcps_pkg::Q_BROWN] = c.brown_low;
    assign q_raw[pfcps_pkg::Q_OPEN] = c.fb_low;
    assign q_raw[pfcps_pkg::Q_FCAN] = c.fb_follow_low & follow_active;
    assign q_raw[pfcps_pkg::Q_OV1] = c.fb_over;
    assign q_raw[pfcps_pkg::Q_OV2] = c.ov2_over;
    // Standby only counts while the reference is up
    assign q_raw[pfcps_pkg::Q_STBY] = c.thr_low & vref_up;

    // Per-channel durations in cycles
    function automatic logic [pfcps_pkg::CNT_W-1:0] q_len(input int i);
        int n;
        n = pfcps_pkg::OV_CYC;
        case (i)
            pfcps_pkg::Q_PCL: n = pfcps_pkg::PCL_CYC;
            pfcps_pkg::Q_BROWN: n = pfcps_pkg::BROWNOUT_CYC;
            pfcps_pkg::Q_OPEN: n = pfcps_pkg::OPEN_LOOP_CYC;
            pfcps_pkg::Q_FCAN: n = pfcps_pkg::FOLLOW_CANCEL_CYC;
            pfcps_pkg::Q_STBY: n = pfcps_pkg::STANDBY_CYC;
            default: n = pfcps_pkg::OV_CYC;
        endcase
        return n[pfcps_pkg::CNT_W-1:0];
    endfunction

    // reload on deassert, count to duration
    for (genvar i = 0; i < pfcps_pkg::NQ; i++) begin : g_qual
        logic [pfcps_pkg::CNT_W-1:0] cnt_q; // Cycles the condition has held
        assign q_hit[i] = (cnt_q == q_len(i));
        always_ff @(posedge clock) begin
            if (!rst_n) begin
                cnt_q <= pfcps_pkg::CNT_RESET;
            end else if (clk_en) begin
                if (!q_raw[i]) begin
                    cnt_q <= pfcps_pkg::CNT_RESET;
                end else if (!q_hit[i]) begin
                    cnt_q <= cnt_q + 1'b1;
                end
            end
        end
    end

    // ----------------------------------------
    // Fault flags with release hysteresis, except open loop
    // ----------------------------------------
    logic brown_q; // Brownout fault held
    logic open_q; // Open-loop fault held
    logic ov1_q; // First over-voltage held
    logic ov2_q; // Second over-voltage held (auto release)
    logic both_q; // Both over-voltages seen together
    logic brown_d;
    logic open_d;
    logic ov1_d;
    logic ov2_d;
    logic both_d;

    // release only above the upper threshold
    assign brown_d = q_hit[pfcps_pkg::Q_BROWN] | (brown_q & ~c.brown_high);
    // release once sense back above threshold
    assign open_d = q_hit[pfcps_pkg::Q_OPEN] | (open_q & c.fb_low);
    assign ov1_d = q_hit[pfcps_pkg::Q_OV1] | (ov1_q & ~c.fb_under_rated);
    assign ov2_d = q_hit[pfcps_pkg::Q_OV2] | (ov2_q & ~c.ov2_under);
    assign both_d = (q_hit[pfcps_pkg::Q_OV1] & q_hit[pfcps_pkg::Q_OV2])
                  | (both_q & (ov1_d | ov2_d));

    // Fault flags, cleared under undervoltage
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            brown_q <= 1'b0;
            open_q <= 1'b0;
            ov1_q <= 1'b0;
            ov2_q <= 1'b0;
            both_q <= 1'b0;
        end else if (clk_en) begin
            brown_q <= brown_d & ~supply_undervoltage_lockout_s;
            open_q <= open_d & ~supply_undervoltage_lockout_s;
            ov1_q <= ov1_d & ~supply_undervoltage_lockout_s;
            ov2_q <= ov2_d & ~supply_undervoltage_lockout_s;
            both_q <= both_d & ~supply_undervoltage_lockout_s;
        end
    end

    // ----------------------------------------
    // Mode sampling and sequencer
    // ----------------------------------------
    logic [pfcps_pkg::CNT_W-1:0] mode_cnt_q; // Sample window counter
    logic [pfcps_pkg::CNT_W-1:0] mode_cnt_d;
    logic latch_q; // Selected second over-voltage mode
    logic latch_d;
    logic hold_fault; // Brownout, open-loop, second or double over-voltage held
    logic restart_d; // One-cycle soft-start request
    logic mode_done;

    assign mode_done = (mode_cnt_q == pfcps_pkg::MODE_SAMPLE_CYC[pfcps_pkg::CNT_W-1:0]);
    assign hold_fault = brown_q | open_q | ov2_q | both_q;

    // Next state; undervoltage forces OFF and drops the restart request
    always_comb begin
        state_d = state_q;
        mode_cnt_d = mode_cnt_q;
        latch_d = latch_q;
        restart_d = 1'b0;
        case (state_q)
            pfcps_pkg::PFCPS_OFF: begin
                mode_cnt_d = pfcps_pkg::CNT_RESET;
                if (!supply_undervoltage_lockout_s) begin
                    state_d = pfcps_pkg::PFCPS_MODE;
                end
            end
            pfcps_pkg::PFCPS_MODE: begin
                // pin level sampled at end of window
                mode_cnt_d = mode_cnt_q + 1'b1;
                if (mode_done) begin
                    latch_d = ~c.thr_low;
                    state_d = pfcps_pkg::PFCPS_WAIT;
                end
            end
            pfcps_pkg::PFCPS_RUN: begin
                if (q_hit[pfcps_pkg::Q_STBY]) begin
                    state_d = pfcps_pkg::PFCPS_STBY;
                end else if (latch_q && q_hit[pfcps_pkg::Q_OV2]
                             && !q_hit[pfcps_pkg::Q_OV1]) begin
                    state_d = pfcps_pkg::PFCPS_LATCH;
                end else if (hold_fault) begin
                    state_d = pfcps_pkg::PFCPS_WAIT;
                end
            end
            pfcps_pkg::PFCPS_WAIT: begin
                if (!hold_fault && !q_hit[pfcps_pkg::Q_OV2]) begin
                    restart_d = 1'b1;
                    state_d = pfcps_pkg::PFCPS_RUN;
                end
            end
            pfcps_pkg::PFCPS_LATCH: begin
                state_d = pfcps_pkg::PFCPS_LATCH;
            end
            pfcps_pkg::PFCPS_STBY: begin
                if (!c.thr_low) begin
                    state_d = pfcps_pkg::PFCPS_WAIT;
                end
            end
            default: begin
                state_d = pfcps_pkg::PFCPS_OFF;
            end
        endcase
        if (supply_undervoltage_lockout_s) begin
            state_d = pfcps_pkg::PFCPS_OFF;
            restart_d = 1'b0;
        end
    end

    // Sequencer registers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_q <= pfcps_pkg::PFCPS_OFF;
            mode_cnt_q <= pfcps_pkg::CNT_RESET;
            latch_q <= 1'b0;
            soft_start_req <= 1'b0;
        end else if (clk_en) begin
            state_q <= state_d;
            mode_cnt_q <= mode_cnt_d;
            latch_q <= latch_d;
            soft_start_req <= restart_d;
        end
    end

    // ----------------------------------------
    // Drive latches
    // ----------------------------------------
    logic pcl_q; // Peak current latch, this cycle
    logic on_q; // Drive-on latch
    logic drive_ok; // No reason to stop switching
    logic drive_d;

    assign drive_ok = (state_q == pfcps_pkg::PFCPS_RUN) & ~hold_fault & ~ov1_q
                    & ~q_hit[pfcps_pkg::Q_OV1] & ~q_hit[pfcps_pkg::Q_OV2] & ~supply_undervoltage_lockout_s;

    // Latches; min-off pulse overrides all inputs
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pcl_q <= 1'b0;
            on_q <= 1'b0;
        end else if (clk_en) begin
            if (min_off_pulse) begin
                pcl_q <= 1'b0;
                on_q <= 1'b0;
            end else begin
                // held off for rest of cycle
                pcl_q <= pcl_q | q_hit[pfcps_pkg::Q_PCL];
                // Refused requests must not linger into a restart
                on_q <= (on_q | pwm_on_req) & drive_ok;
            end
        end
    end

    // immediate cut in the qualifying cycle
    assign drive_d = on_q & ~pcl_q & ~q_hit[pfcps_pkg::Q_PCL] & ~min_off_pulse & drive_ok;

    // ----------------------------------------
    // Boost follower and bulk good
    // ----------------------------------------
    logic follow_q; // Follower allowed (not cancelled)
    logic bulk_q; // Bulk-good output level

    // light load lost when input held high
    assign follow_active = follow_q & c.brown_lowline & c.load_light & ~soft_start_active
                         & (state_q == pfcps_pkg::PFCPS_RUN);

    // Follower permit, bulk-good and gate registers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            follow_q <= 1'b0;
            bulk_q <= 1'b0;
            gate_drive <= 1'b0;
        end else if (clk_en) begin
            if (q_hit[pfcps_pkg::Q_FCAN] || state_q != pfcps_pkg::PFCPS_RUN) begin
                follow_q <= 1'b0;
            end else if (soft_start_req) begin
                follow_q <= 1'b1;
            end
            // set at 95 percent during soft start
            if (supply_undervoltage_lockout_s || state_q == pfcps_pkg::PFCPS_STBY) begin
                bulk_q <= 1'b0;
            end else if (soft_start_active && c.bulk_95) begin
                bulk_q <= 1'b1;
            end else if (c.bulk_low_thr) begin
                bulk_q <= 1'b0;
            end
            gate_drive <= drive_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign bulk_good_out = bulk_q;
    assign follower_current_en = follow_active;
    assign latch_mode = latch_q;
    assign standby = (state_q == pfcps_pkg::PFCPS_STBY);
    assign peak_current_limit = pcl_q;
    assign open_loop_fault = open_q;
    assign first_overvoltage_fault = ov1_q;
    assign second_overvoltage_fault = ov2_q | (state_q == pfcps_pkg::PFCPS_LATCH);

endmodule

// [test/pfcps_analog_model.sv]
// Comparator model standing in for the analog pins
`timescale 1ns/10ps
module pfcps_analog_model (
    // Pin levels in mV, bulk in percent of rated
    input int shunt_mv,
    input int brown_mv,
    input int fb_mv,
    input int ov2_mv,
    input int thr_mv,
    input int load_mv,
    input int bulk_pct,
    input int low_pct,
    // Decisions to the sequencer
    output wire pfcps_pkg::pfcps_cmp_t cmp
);
    assign cmp.shunt_over = shunt_mv <= -200;
    assign cmp.brown_low = brown_mv < 1000;
    assign cmp.brown_high = brown_mv > 1250;
    assign cmp.brown_lowline = brown_mv < 2300;
    assign cmp.fb_low = fb_mv < 500;
    assign cmp.fb_follow_low = fb_mv < 800;
    assign cmp.fb_over = fb_mv > 2700;
    assign cmp.fb_under_rated = fb_mv < 2500;
    assign cmp.ov2_over = ov2_mv > 2500;
    assign cmp.ov2_under = ov2_mv < 2300;
    assign cmp.thr_low = thr_mv < 500;
    assign cmp.load_light = load_mv < 500;
    assign cmp.bulk_95 = bulk_pct > 95;
    assign cmp.bulk_low_thr = bulk_pct < low_pct;
endmodule

// [test/pfcps_sequencer_chk.sv]
// Assertion checker for the protection fault sequencer
`timescale 1ns/10ps
module pfcps_sequencer_chk (
    // Clock and reset
    input logic clock,
    input logic rst_n,
    input logic clk_en,
    // Inputs
    input pfcps_pkg::pfcps_cmp_t cmp_in,
    input logic supply_undervoltage_lockout,
    input logic vref_up,
    input logic min_off_pulse,
    input logic pwm_on_req,
    input logic soft_start_active,
    // Outputs
    input logic gate_drive,
    input logic soft_start_req,
    input logic bulk_good_out,
    input logic follower_current_en,
    input logic latch_mode,
    input logic standby,
    input logic peak_current_limit,
    input logic open_loop_fault,
    input logic first_overvoltage_fault,
    input logic second_overvoltage_fault
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Two sync flops plus the drive register
    supply_undervoltage_lockout_gate_off_a: assert property (supply_undervoltage_lockout [*4] |-> !gate_drive)
        else $error("drive high under lockout");
    pcl_gate_off_a: assert property (peak_current_limit |=> !gate_drive)
        else $error("drive high with peak latch");
    // Span covers both readings of the hit edge
    pcl_deglitch_a: assert property ($rose(peak_current_limit) |->
        $past(cmp_in.shunt_over, 4) && $past(cmp_in.shunt_over, 12))
        else $error("peak latch without held shunt");
    min_off_clear_a: assert property (min_off_pulse |-> ##2 !gate_drive)
        else $error("drive survives off pulse");
    gate_cause_a: assert property ($rose(gate_drive) |-> $past(pwm_on_req, 2))
        else $error("drive rose without request");
    ss_pulse_a: assert property (soft_start_req |=> !soft_start_req)
        else $error("restart request too long");
    ov2_gate_off_a: assert property (second_overvoltage_fault |=> !gate_drive)
        else $error("drive high in overvoltage");
    ov1_gate_off_a: assert property (first_overvoltage_fault |=> !gate_drive)
        else $error("drive high in first overvoltage");
    standby_gate_off_a: assert property (standby |=> !gate_drive)
        else $error("drive high in standby");
    follow_cond_a: assert property (follower_current_en |->
        $past(cmp_in.brown_lowline, 2) && $past(cmp_in.load_light, 2))
        else $error("follower source without cause");
    ss_follow_off_a: assert property (soft_start_active [*2] |-> !follower_current_en)
        else $error("follower on in soft start");
    // Main scenarios reached
    cover property ($rose(peak_current_limit));
    cover property (second_overvoltage_fault && latch_mode);
    cover property (follower_current_en);
endmodule
bind pfcps_sequencer pfcps_sequencer_chk pfcps_sequencer_chk_i (.*);

// [test/pfcps_sequencer_tb.sv]
// Self-checking testbench for the protection fault sequencer
`timescale 1ns/10ps
module pfcps_sequencer_tb;
    // Stimulus, all changed 1 ns after the edge
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic supply_undervoltage_lockout = 1'b1;
    logic vref_up = 1'b1;
    logic min_off_pulse = 1'b0;
    logic pwm_on_req = 1'b0;
    logic soft_start_active = 1'b0;
    logic clk_en = 1'b1;
    int shunt_mv = 0;
    int brown_mv = 2500;
    int fb_mv = 2500;
    int ov2_mv = 2000;
    int thr_mv = 3000;
    int load_mv = 1000;
    int bulk_pct = 90;
    int low_pct = 80;
    // Comparator model and design outputs
    wire pfcps_pkg::pfcps_cmp_t cmp_in;
    logic gate_drive, soft_start_req, bulk_good_out, follower_current_en, latch_mode;
    logic standby, peak_current_limit, open_loop_fault, first_ov, second_ov;
    // Tallies
    int fails = 0;
    int total_checks = 0;
    logic got;
    always #10 clock = ~clock;
    pfcps_analog_model pfcps_analog_model_i (.shunt_mv(shunt_mv), .brown_mv(brown_mv),
        .fb_mv(fb_mv), .ov2_mv(ov2_mv), .thr_mv(thr_mv), .load_mv(load_mv),
        .bulk_pct(bulk_pct), .low_pct(low_pct), .cmp(cmp_in));
    // Clock enable is dropped by the freeze scenario only
    pfcps_sequencer pfcps_sequencer_i (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
        .cmp_in(cmp_in), .supply_undervoltage_lockout(supply_undervoltage_lockout),
        .vref_up(vref_up), .min_off_pulse(min_off_pulse), .pwm_on_req(pwm_on_req),
        .soft_start_active(soft_start_active), .gate_drive(gate_drive),
        .soft_start_req(soft_start_req), .bulk_good_out(bulk_good_out),
        .follower_current_en(follower_current_en), .latch_mode(latch_mode),
        .standby(standby), .peak_current_limit(peak_current_limit),
        .open_loop_fault(open_loop_fault), .first_overvoltage_fault(first_ov),
        .second_overvoltage_fault(second_ov));
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic chk(input string what, input logic seen, input logic exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %b seen %b", what, exp, seen);
        end
    endtask
    // Bounded wait for the one-cycle restart pulse
    task automatic wait_ss(input int lim);
        got = 1'b0;
        for (int i = 0; i < lim && !got; i++) begin
            cyc(1);
            got = (soft_start_req === 1'b1);
        end
    endtask
    // One switching cycle: off pulse, then on request
    task automatic fire(input logic exp);
        min_off_pulse = 1'b1;
        cyc(1);
        min_off_pulse = 1'b0;
        pwm_on_req = 1'b1;
        cyc(1);
        pwm_on_req = 1'b0;
        cyc(1);
        chk("gate_drive", gate_drive, exp);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Start-up from lockout; auto mode holds the enable pin low with reference down
    task automatic t_start(input logic mode);
        cyc(5);
        chk("gate_drive", gate_drive, 1'b0);
        thr_mv = mode ? 3000 : 300;
        vref_up = mode;
        supply_undervoltage_lockout = 1'b0;
        wait_ss(880);
        chk("early restart", got, 1'b0);
        wait_ss(60);
        chk("soft_start_req", got, 1'b1);
        chk("latch_mode", latch_mode, mode);
        thr_mv = 3000;
        vref_up = 1'b1;
        fire(1'b1);
    endtask
    task automatic t_pcl();
        shunt_mv = -250;
        cyc(9);
        shunt_mv = 0;
        cyc(4);
        chk("short glitch", peak_current_limit, 1'b0);
        chk("gate_drive", gate_drive, 1'b1);
        shunt_mv = -250;
        cyc(14);
        chk("peak_current_limit", peak_current_limit, 1'b1);
        chk("gate_drive", gate_drive, 1'b0);
        pwm_on_req = 1'b1;
        cyc(1);
        pwm_on_req = 1'b0;
        cyc(1);
        chk("refused request", gate_drive, 1'b0);
        shunt_mv = 0;
        cyc(3);
        fire(1'b1);
    endtask
    task automatic t_brown();
        brown_mv = 800;
        cyc(990);
        chk("gate_drive", gate_drive, 1'b1);
        cyc(20);
        chk("gate_drive", gate_drive, 1'b0);
        brown_mv = 1100;
        wait_ss(50);
        chk("restart in hysteresis", got, 1'b0);
        brown_mv = 2000;
        wait_ss(20);
        chk("soft_start_req", got, 1'b1);
    endtask
    // Follower and bulk-good after a fresh restart; brownout input sits at low line
    task automatic t_follow();
        soft_start_active = 1'b1;
        load_mv = 300;
        bulk_pct = 96;
        cyc(5);
        chk("follower in soft start", follower_current_en, 1'b0);
        chk("bulk_good_out", bulk_good_out, 1'b1);
        soft_start_active = 1'b0;
        low_pct = 97;
        cyc(4);
        chk("bulk_good_out", bulk_good_out, 1'b0);
        chk("follower_current_en", follower_current_en, 1'b1);
        load_mv = 1000;
        cyc(4);
        chk("follower heavy load", follower_current_en, 1'b0);
        load_mv = 300;
        fb_mv = 700;
        cyc(60);
        chk("follower cancel", follower_current_en, 1'b0);
        fb_mv = 2500;
        brown_mv = 2500;
        fire(1'b1);
    endtask
    task automatic t_standby();
        thr_mv = 300;
        cyc(440);
        chk("standby", standby, 1'b0);
        cyc(20);
        chk("standby", standby, 1'b1);
        thr_mv = 3000;
        wait_ss(50);
        chk("soft_start_req", got, 1'b1);
        fire(1'b1);
    endtask
    // Frozen clock enable ignores a long shunt event
    task automatic t_freeze();
        clk_en = 1'b0;
        shunt_mv = -250;
        cyc(20);
        chk("frozen peak", peak_current_limit, 1'b0);
        shunt_mv = 0;
        cyc(1);
        clk_en = 1'b1;
        cyc(12);
        chk("peak after thaw", peak_current_limit, 1'b0);
        chk("gate_drive", gate_drive, 1'b1);
    endtask
    // Feedback faults: first overvoltage, both together, then open loop
    task automatic t_fb();
        fb_mv = 2800;
        cyc(60);
        chk("first_ov", first_ov, 1'b0);
        cyc(560);
        chk("first_ov", first_ov, 1'b1);
        chk("gate_drive", gate_drive, 1'b0);
        fb_mv = 2600;
        cyc(5);
        chk("first_ov hysteresis", first_ov, 1'b1);
        fb_mv = 2400;
        cyc(4);
        chk("first_ov", first_ov, 1'b0);
        fire(1'b1);
        // Both together in latch mode must not latch
        fb_mv = 2800;
        ov2_mv = 2600;
        cyc(620);
        chk("second_ov", second_ov, 1'b1);
        chk("gate_drive", gate_drive, 1'b0);
        fb_mv = 2400;
        ov2_mv = 2400;
        wait_ss(50);
        chk("restart before both clear", got, 1'b0);
        ov2_mv = 2000;
        wait_ss(20);
        chk("restart after both clear", got, 1'b1);
        fire(1'b1);
        fb_mv = 300;
        cyc(45);
        chk("open_loop_fault", open_loop_fault, 1'b0);
        cyc(10);
        chk("open_loop_fault", open_loop_fault, 1'b1);
        chk("gate_drive", gate_drive, 1'b0);
        fb_mv = 2500;
        wait_ss(20);
        chk("soft_start_req", got, 1'b1);
        chk("open_loop_fault", open_loop_fault, 1'b0);
        fire(1'b1);
    endtask
    // Second overvoltage; latch mode waits for lockout, auto mode for the low level
    task automatic t_ov2(input logic mode);
        ov2_mv = 2600;
        cyc(620);
        chk("second_ov", second_ov, 1'b1);
        chk("gate_drive", gate_drive, 1'b0);
        ov2_mv = mode ? 2000 : 2400;
        wait_ss(100);
        chk("restart too soon", got, 1'b0);
        ov2_mv = 2000;
        wait_ss(20);
        chk("auto restart", got, !mode);
    endtask
    initial begin
        cyc(2);
        rst_n = 1'b1;
        t_start(1'b1);
        t_pcl();
        t_freeze();
        t_brown();
        t_follow();
        t_standby();
        t_fb();
        t_ov2(1'b1);
        supply_undervoltage_lockout = 1'b1;
        t_start(1'b0);
        chk("second_ov", second_ov, 1'b0);
        t_ov2(1'b0);
        end_sim();
    end
    // Watchdog well past the expected run of some 6300 cycles
    initial begin
        #(20 * 30000);
        fails++;
        end_sim();
    end
endmodule
